// *** rtl/ilpft_pkg.sv ***
// Constants and types for the interleaved converter trip and drive block
`default_nettype none
package ilpft_pkg;
    // =====================================================================
    // Register byte offsets
    localparam logic [7:0] ILPFT_CTRL     = 8'h00;
    localparam logic [7:0] ILPFT_HALF     = 8'h04;
    localparam logic [7:0] ILPFT_DEAD     = 8'h08;
    localparam logic [7:0] ILPFT_THR_P1   = 8'h0c;
    localparam logic [7:0] ILPFT_THR_IO   = 8'h10;
    localparam logic [7:0] ILPFT_THR_VO   = 8'h14;
    localparam logic [7:0] ILPFT_THR_P2   = 8'h18;
    localparam logic [7:0] ILPFT_SHARE    = 8'h1c;
    localparam logic [7:0] ILPFT_STATUS   = 8'h20;
    localparam logic [7:0] ILPFT_MASK     = 8'h24;
    localparam logic [7:0] ILPFT_STATE    = 8'h28;
    localparam logic [7:0] ILPFT_VOUT     = 8'h2c;
    localparam logic [7:0] ILPFT_MODE_THR = 8'h30;
    // =====================================================================
    // Status bit positions
    localparam int ILPFT_ST_TRIP  = 0;
    localparam int ILPFT_ST_SHARE = 4;
    localparam int ILPFT_ST_UPD   = 5;
    localparam int ILPFT_ST_W     = 6;
    // =====================================================================
    // Values after reset
    localparam logic [15:0] ILPFT_HALF_RST = 16'h0190;
    localparam logic [15:0] ILPFT_DEAD_RST = 16'h0010;
    localparam logic [11:0] ILPFT_THR_RST  = 12'hfff;
    localparam logic [11:0] ILPFT_SHR_RST  = 12'h100;
    localparam logic [11:0] ILPFT_MODE_RST = 12'h200;
    // =====================================================================
    // Timing
    localparam int ILPFT_CLK_HZ  = 200_000_000;
    localparam int ILPFT_UPD_HZ  = 50_000;
    localparam int ILPFT_UPD_CYC = ILPFT_CLK_HZ / ILPFT_UPD_HZ;
    localparam logic [11:0] ILPFT_UPD_LAST = 12'(ILPFT_UPD_CYC - 1);
    // =====================================================================
    // Types
    typedef enum logic [3:0] {
        ILPFT_IDLE    = 4'b0001,
        ILPFT_SAMPLE  = 4'b0010,
        ILPFT_COMPUTE = 4'b0100,
        ILPFT_LOAD    = 4'b1000
    } ilpft_upd_e;
    typedef struct packed {
        logic p1_high; logic p1_low; logic p1_rect_a; logic p1_rect_b;
        logic p2_high; logic p2_low; logic p2_rect_a; logic p2_rect_b;
    } ilpft_drive_s;
    typedef struct packed {
        logic [11:0] p1_pri; logic [11:0] iout;
        logic [11:0] vout;   logic [11:0] p2_pri;
    } ilpft_sense_s;
endpackage
`default_nettype wire

// *** rtl/ilpft_top.sv ***
// Trip latch, interleaved drive generation and control update sequencing
// =========================================================================
// What this block does
// - Detect primary overcurrent per phase with its own comparator.
// - Output overcurrent and overvoltage detections are faults.
// - Each comparator threshold is its own 12-bit reference value.
// - A limit crossing raises a one-shot trip to all four PWM units.
// - On trip, all eight drive outputs go low at once.
// - Trip latch holds outputs low until reset only.
// - Tank current difference is compared to a programmable threshold.
// - Output current feeds mode selection and overcurrent protection.
// - Control update triggered by a timer at 50 kHz.
// - Update order: take readings, compute, then load PWM settings.
// - Output voltage for the loop is a 12-bit sample.
// - Bridge units channel A high side, channel B low side.
// - Rectifier units channel A and B drive rectifier A and B.
// - Separate fault lamp and system good lamp outputs.
// - Half bridge sides complementary at 50% with dead time.
// - The two phases run 180 degrees apart at every frequency.
//
// The implementer's own choices: the address map and the AHB-Lite slave port.
`default_nettype none
module ilpft_top
#(
    parameter int CW = 16
) (
    // Clock and reset
    input  wire logic                hclk,
    input  wire logic                hresetn,
    // AHB-Lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    // Converter readings, same clock
    input  wire ilpft_pkg::ilpft_sense_s sense,
    // Drives and lamps
    output ilpft_pkg::ilpft_drive_s  drive,
    output logic                     fault_lamp,
    output logic                     system_ok_indicator,
    output logic                     irq
);
    import ilpft_pkg::*;
    default clocking chk_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic [CW-1:0]          half, dead, half_act, dead_act, cnt;
    logic                   enable;
    logic [11:0]            thr [4];
    logic [11:0]            share_thr, mode_thr, vout_smp;
    localparam int ST_WL = ILPFT_ST_W;
    logic [ST_WL-1:0]       status, mask;
    logic [3:0]             over, over_q, trip_pulse;
    logic                   trip_now, trip_latch;
    logic                   share_bad, light_load, upd_done;
    logic [11:0]            p1_smp, p2_smp, io_smp, diff;
    logic [11:0]            tick_cnt;
    logic                   tick;
    ilpft_upd_e             st;
    ilpft_drive_s           pwm;
    logic                   ap_wr, ap_rd;
    logic [7:0]             ap_addr;
    logic [11:0]            sval [4];

    // =====================================================================
    // Bus slave: zero wait, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign ap_rd = hsel && hready && htrans[1] && !hwrite;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_wr   <= 1'b0;
            ap_addr <= 8'h00;
        end
        else
        begin
            ap_wr   <= hsel && hready && htrans[1] && hwrite;
            ap_addr <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0;
        else if (ap_rd)
            case (haddr[7:0])
                ILPFT_CTRL:     hrdata <= {31'h0, enable};
                ILPFT_HALF:     hrdata <= 32'(half);
                ILPFT_DEAD:     hrdata <= 32'(dead);
                ILPFT_THR_P1:   hrdata <= {20'h0, thr[0]};
                ILPFT_THR_IO:   hrdata <= {20'h0, thr[1]};
                ILPFT_THR_VO:   hrdata <= {20'h0, thr[2]};
                ILPFT_THR_P2:   hrdata <= {20'h0, thr[3]};
                ILPFT_SHARE:    hrdata <= {20'h0, share_thr};
                ILPFT_STATUS:   hrdata <= 32'(status);
                ILPFT_MASK:     hrdata <= 32'(mask);
                ILPFT_STATE:    hrdata <= {28'h0, light_load, share_bad,
                                           st == ILPFT_IDLE, trip_latch};
                ILPFT_VOUT:     hrdata <= {20'h0, vout_smp};
                ILPFT_MODE_THR: hrdata <= {20'h0, mode_thr};
                default:        hrdata <= 32'h0;
            endcase
    end

    // Control registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            enable    <= 1'b0;
            half      <= CW'(ILPFT_HALF_RST);
            dead      <= CW'(ILPFT_DEAD_RST);
            thr       <= '{default: ILPFT_THR_RST};
            share_thr <= ILPFT_SHR_RST;
            mode_thr  <= ILPFT_MODE_RST;
            mask      <= '0;
        end
        else if (ap_wr)
            case (ap_addr)
                ILPFT_CTRL:     enable    <= hwdata[0];
                ILPFT_HALF:     half      <= hwdata[CW-1:0];
                ILPFT_DEAD:     dead      <= hwdata[CW-1:0];
                ILPFT_THR_P1:   thr[0]    <= hwdata[11:0];
                ILPFT_THR_IO:   thr[1]    <= hwdata[11:0];
                ILPFT_THR_VO:   thr[2]    <= hwdata[11:0];
                ILPFT_THR_P2:   thr[3]    <= hwdata[11:0];
                ILPFT_SHARE:    share_thr <= hwdata[11:0];
                ILPFT_MASK:     mask      <= hwdata[ST_WL-1:0];
                ILPFT_MODE_THR: mode_thr  <= hwdata[11:0];
                default:        ;
            endcase
    end

    // =====================================================================
    // Comparators and one-shot trip
    assign sval[0] = sense.p1_pri;
    assign sval[1] = sense.iout;
    assign sval[2] = sense.vout;
    assign sval[3] = sense.p2_pri;
    generate
        for (genvar i = 0; i < 4; i++)
        begin : g_cmp
            assign over[i]       = sval[i] > thr[i];
            assign trip_pulse[i] = over[i] && !over_q[i];
        end
    endgenerate
    assign trip_now = |trip_pulse;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            over_q     <= 4'h0;
            trip_latch <= 1'b0;
        end
        else
        begin
            over_q <= over;
            if (trip_now)
                trip_latch <= 1'b1;
        end
    end

    // =====================================================================
    // Update trigger and sequence
    assign tick = (tick_cnt == ILPFT_UPD_LAST);
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            tick_cnt <= 12'h0;
        else
            tick_cnt <= tick ? 12'h0 : tick_cnt + 12'h1;
    end
    assign diff = (p1_smp > p2_smp) ? p1_smp - p2_smp : p2_smp - p1_smp;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st         <= ILPFT_IDLE;
            p1_smp     <= 12'h0;
            p2_smp     <= 12'h0;
            io_smp     <= 12'h0;
            vout_smp   <= 12'h0;
            share_bad  <= 1'b0;
            light_load <= 1'b0;
            half_act   <= CW'(ILPFT_HALF_RST);
            dead_act   <= CW'(ILPFT_DEAD_RST);
            upd_done   <= 1'b0;
        end
        else
        begin
            upd_done <= 1'b0;
            case (st)
                ILPFT_IDLE:
                    if (tick)
                        st <= ILPFT_SAMPLE;
                ILPFT_SAMPLE:
                begin
                    p1_smp   <= sense.p1_pri;
                    p2_smp   <= sense.p2_pri;
                    io_smp   <= sense.iout;
                    vout_smp <= sense.vout;
                    st       <= ILPFT_COMPUTE;
                end
                ILPFT_COMPUTE:
                begin
                    share_bad  <= diff > share_thr;
                    light_load <= io_smp < mode_thr;
                    st         <= ILPFT_LOAD;
                end
                ILPFT_LOAD:
                begin
                    half_act <= half;
                    dead_act <= dead;
                    upd_done <= 1'b1;
                    st       <= ILPFT_IDLE;
                end
                default:
                    st <= ILPFT_IDLE;
            endcase
        end
    end

    // =====================================================================
    // Interleaved PWM with dead time
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt <= '0;
            pwm <= '0;
        end
        else
        begin
            if (!enable || cnt >= CW'((half_act << 1) - CW'(1)))
                cnt <= '0;
            else
                cnt <= cnt + CW'(1);
            pwm.p1_high   <= enable && cnt >= dead_act && cnt < half_act;
            pwm.p1_low    <= enable && cnt >= half_act + dead_act;
            pwm.p2_high   <= enable && cnt >= half_act + dead_act;
            pwm.p2_low    <= enable && cnt >= dead_act && cnt < half_act;
            pwm.p1_rect_a <= enable && cnt >= dead_act && cnt < half_act;
            pwm.p1_rect_b <= enable && cnt >= half_act + dead_act;
            pwm.p2_rect_a <= enable && cnt >= half_act + dead_act;
            pwm.p2_rect_b <= enable && cnt >= dead_act && cnt < half_act;
        end
    end

    // Trip gates all eight drives in the same cycle
    assign drive = (trip_now || trip_latch) ? '0 : pwm;

    // =====================================================================
    // Lamps, status and interrupt
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fault_lamp          <= 1'b0;
            system_ok_indicator <= 1'b0;
        end
        else
        begin
            fault_lamp          <= trip_latch;
            system_ok_indicator <= !trip_latch;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            status <= '0;
        else
        begin
            for (int b = 0; b < ST_WL; b++)
            begin
                if (ap_wr && ap_addr == ILPFT_STATUS && hwdata[b])
                    status[b] <= 1'b0;
                if (b < 4 && trip_pulse[b % 4])
                    status[b] <= 1'b1;
            end
            if (st == ILPFT_COMPUTE && diff > share_thr)
                status[ILPFT_ST_SHARE] <= 1'b1;
            if (upd_done)
                status[ILPFT_ST_UPD] <= 1'b1;
        end
    end
    assign irq = |(status & mask);

    // =====================================================================
    // Checks
    sequence upd_walk_s;
        st == ILPFT_SAMPLE ##1 st == ILPFT_COMPUTE ##1 st == ILPFT_LOAD;
    endsequence
    sequence lamps_fault_s;
        fault_lamp && !system_ok_indicator;
    endsequence

    trip_force_a: assert property (trip_now |-> drive == '0)
        else $error("drives not forced low on trip");
    trip_hold_a: assert property (
        trip_latch |=> trip_latch && drive == '0)
        else $error("trip latch released");
    phase_over_a: assert property (
        (over[0] || over[3]) |=> trip_latch)
        else $error("phase overcurrent missed");
    out_fault_a: assert property (
        |trip_pulse[2:1] |=> trip_latch && |status[2:1])
        else $error("output fault missed");
    fault_lamp_a: assert property (
        $rose(trip_latch) |=> lamps_fault_s ##1 lamps_fault_s)
        else $error("lamps wrong after trip");
    bridge_comp_a: assert property (
        !(drive.p1_high && drive.p1_low) && !(drive.p2_high && drive.p2_low))
        else $error("bridge shoot-through");
    interleave_a: assert property (
        drive.p1_high |-> !drive.p2_high)
        else $error("phases not opposed");
    upd_order_a: assert property (
        (st == ILPFT_IDLE && tick) |=> upd_walk_s)
        else $error("update order broken");
    upd_rate_a: assert property (tick |=> !tick [*8])
        else $error("update tick too fast");

endmodule // ilpft_top
`default_nettype wire

// *** tb/ilpft_gate_model.sv ***
// Gate driver model that flags cross-conduction on the drive lines
`default_nettype none
module ilpft_gate_model
    import ilpft_pkg::*;
(
    // Clock and reset
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    // Drive lines from the block
    input  wire ilpft_pkg::ilpft_drive_s drive,
    // Cross-conduction seen since reset
    output var logic                     overlap
);
    timeunit 1ns;
    timeprecision 1ps;
    // =====================================================================
    // Both switches of one leg on together
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            overlap <= 1'b0;
        else if ((drive.p1_high && drive.p1_low)
                 || (drive.p2_high && drive.p2_low))
            overlap <= 1'b1;
    end
endmodule // ilpft_gate_model
`default_nettype wire

// *** tb/ilpft_top_tb.sv ***
// Self-checking bench for the trip, drive and update block
`default_nettype none
module ilpft_top_tb;
    import ilpft_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic         hclk, hresetn, hsel, hwrite, hready, hresp;
    logic         hreadyout, fault_lamp, system_ok_indicator, irq;
    logic         overlap;
    logic [1:0]   htrans;
    logic [2:0]   hsize;
    logic [31:0]  haddr, hwdata, hrdata, rd;
    ilpft_sense_s sense;
    ilpft_drive_s drive;
    int           fails, n_tests, cyc, n, t0, c1, c2, bad;
    assign hready = hreadyout;
    ilpft_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .sense(sense), .drive(drive),
        .fault_lamp(fault_lamp), .system_ok_indicator(system_ok_indicator),
        .irq(irq));
    ilpft_gate_model gates (.hclk(hclk), .hresetn(hresetn), .drive(drive),
        .overlap(overlap));
    // =====================================================================
    // Clock and watchdog
    initial hclk = 1'b0;
    always #2.5 hclk = ~hclk;
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            fails++;
            report_and_stop();
        end
    end
    // =====================================================================
    // Helpers
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp)
        begin
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
            fails++;
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] wd);
        int k;
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        hsize  <= 3'b010;
        k = 0;
        do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 50);
        htrans <= 2'b00;
        hwdata <= wd;
        k = 0;
        do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 50);
        rd = hrdata;
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] msk, exp);
        xfer(a, 1'b0, 32'h00000000);
        check(nm, rd & msk, exp);
    endtask
    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask
    task automatic wait_cyc(input logic want, input int lim);
        n = 0;
        do begin @(posedge hclk); #1; n++; end
        while (((irq === want) == 0) && n < lim);
    endtask
    task automatic setup_pwm(input logic [11:0] thr);
        xfer(ILPFT_THR_P1, 1'b1, {20'h0, thr});
        xfer(ILPFT_THR_IO, 1'b1, {20'h0, thr});
        xfer(ILPFT_THR_VO, 1'b1, {20'h0, thr});
        xfer(ILPFT_THR_P2, 1'b1, {20'h0, thr});
        xfer(ILPFT_HALF, 1'b1, 32'h00000020);
        xfer(ILPFT_DEAD, 1'b1, 32'h00000004);
        xfer(ILPFT_CTRL, 1'b1, 32'h00000001);
    endtask
    function automatic ilpft_sense_s mk(input int i, input logic [11:0] v);
        return ilpft_sense_s'({36'h0, v} << (12 * (3 - i)));
    endfunction
    // =====================================================================
    // Main sequence
    initial
    begin
        hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00;
        hwrite = 1'b0; hsize = 3'b010; hwdata = '0; sense = '0;
        fails = 0; n_tests = 0; cyc = 0;
        do_reset();
        #1 check("ok lamp", system_ok_indicator, 1'b1);
        check("fault lamp", fault_lamp, 1'b0);
        check("hresp", hresp, 1'b0);
        @(posedge hclk);
        rd_chk("half rst", ILPFT_HALF, '1, 32'h190);
        rd_chk("dead rst", ILPFT_DEAD, '1, 32'h10);
        rd_chk("thr rst", ILPFT_THR_VO, '1, 32'hfff);
        rd_chk("share rst", ILPFT_SHARE, '1, 32'h100);
        rd_chk("mode rst", ILPFT_MODE_THR, '1, 32'h200);
        rd_chk("unmapped", 8'h3c, '1, 32'h0);
        sense <= '{12'h300, 12'h100, 12'h5a5, 12'h100};
        setup_pwm(12'h800);
        xfer(ILPFT_MASK, 1'b1, 32'h00000020);
        wait_cyc(1'b1, 4100);
        t0 = cyc;
        check("upd irq", irq, 1'b1);
        @(posedge hclk);
        xfer(ILPFT_STATUS, 1'b1, 32'h00000020);
        @(posedge hclk); #1;
        check("irq clr", irq, 1'b0);
        wait_cyc(1'b1, 4100);
        check("upd period", cyc - t0, 32'd4000);
        @(posedge hclk);
        rd_chk("share flag", ILPFT_STATUS, 32'h30, 32'h30);
        rd_chk("mode state", ILPFT_STATE, 32'hc, 32'hc);
        rd_chk("vout", ILPFT_VOUT, '1, 32'h5a5);
        c1 = 0; c2 = 0; bad = 0;
        repeat (128)
        begin
            @(posedge hclk); #1;
            c1 += drive.p1_high;
            c2 += drive.p1_low;
            bad += (drive.p2_low != drive.p1_high)
                   || (drive.p2_high != drive.p1_low);
            bad += (drive.p1_rect_a != drive.p1_high)
                   || (drive.p2_rect_b != drive.p1_high);
        end
        check("high on", c1, 32'd56);
        check("low on", c2, 32'd56);
        check("phase", bad, 32'd0);
        check("overlap", overlap, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            sense <= '0;
            do_reset();
            setup_pwm(12'h800);
            n = 0;
            do begin @(posedge hclk); n++; end
            while (drive == '0 && n < 4200);
            sense <= mk(i, 12'h800);
            repeat (3) @(posedge hclk); #1;
            check("no trip eq", fault_lamp, 1'b0);
            do @(posedge hclk); while (drive == '0);
            sense <= mk(i, 12'h801);
            #1 check("drive cut", drive, 8'h00);
            repeat (2) @(posedge hclk); #1;
            check("fault on", fault_lamp, 1'b1);
            check("ok off", system_ok_indicator, 1'b0);
            @(posedge hclk);
            sense <= '0;
            bad = 0;
            repeat (900) begin @(posedge hclk); #1; bad += (drive != '0); end
            check("held low", bad, 32'd0);
            check("fault held", fault_lamp, 1'b1);
            @(posedge hclk);
            rd_chk("src", ILPFT_STATUS, 32'hf, 32'h1<<i);
        end
        do_reset();
        #1 check("ok back", system_ok_indicator, 1'b1);
        check("fault clr", fault_lamp, 1'b0);
        report_and_stop();
    end
endmodule // ilpft_top_tb
`default_nettype wire
